// >>> common/jbs_pkg.sv
// Purpose: Shared constants and types for the boundary-scan test port
// Assumes: Test clock sampled by the 100 MHz system clock
// Notes:   Identification value is a parameter default, arbitrary
package jbs_pkg;

  localparam int IR_W = 6;

  localparam logic [5:0] IR_BYPASS   = 6'h3F;
  localparam logic [5:0] IR_SAMPLE   = 6'h04;
  localparam logic [5:0] IR_EXTEST   = 6'h01;
  localparam logic [5:0] IR_HIGHZ    = 6'h03;
  localparam logic [5:0] IR_IDCODE   = 6'h0A;
  localparam logic [5:0] IR_RESET    = IR_IDCODE;

  // Capture pattern of the instruction register
  localparam logic [5:0] IR_CAPTURE  = 6'h01;

  // Arbitrary neutral identification value, bit 0 must be one
  localparam logic [31:0] IDCODE_DEF = 32'h1234_5671;

  localparam int ID_W = 32;

  typedef enum logic [1:0] {
    JBS_SEL_BYPASS,
    JBS_SEL_IDCODE,
    JBS_SEL_BSR
  } jbs_sel_t;

  // Test pins after synchronisation
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jbs_pins_t;

endpackage : jbs_pkg

// >>> design/jbs_tap.sv
// Purpose: Boundary-scan test access port with state machine, IR, bypass, ID and BSR
// Assumes: Test clock far slower than clock; pins pass two flip-flops first
// Notes:   Cell count is a parameter; one cell per digital pin in the chain
`timescale 1ns/10ps

module jbs_tap #(
  parameter int          NCELL  = 16,
  parameter logic [31:0] IDCODE = jbs_pkg::IDCODE_DEF
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             tck,
  input  wire logic             tms,
  input  wire logic             tdi,
  input  wire logic             trst_n,
  output logic                  tdo,
  output logic                  tdo_oe,
  input  wire logic [NCELL-1:0] core_out,
  input  wire logic [NCELL-1:0] core_oe,
  output logic      [NCELL-1:0] core_in,
  input  wire logic [NCELL-1:0] pad_in,
  output logic      [NCELL-1:0] pad_out,
  output logic      [NCELL-1:0] pad_oe
);

  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PA_DR, S_EX2_DR, S_UP_DR,
    S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PA_IR, S_EX2_IR, S_UP_IR
  } jbs_state_t;

  // Two-stage synchronisers; first stage read only by second
  // Third stage only remembers the last test clock level for edge finding
  jbs_pkg::jbs_pins_t s1_q, s2_q, s3_q;
  logic               rise, fall, trst_act;
  // Pin levels resynchronised too, so capture never sees a moving pin
  logic [NCELL-1:0]   pin1_q, pin2_q;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      pin1_q <= '0;
      pin2_q <= '0;
    end
    else
    begin
      s1_q <= '{tck: tck, tms: tms, tdi: tdi, trst_n: trst_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin1_q <= pad_in;
      pin2_q <= pin1_q;
    end
  end

  assign rise     = s2_q.tck & ~s3_q.tck;
  assign fall     = ~s2_q.tck & s3_q.tck;
  assign trst_act = ~s2_q.trst_n;

  jbs_state_t            st_q, st_d;
  logic [5:0]            ir_q, ir_d, irs_q, irs_d;
  logic                  byp_q, byp_d;
  logic [31:0]           id_q, id_d;
  logic [NCELL-1:0]      bs_q, bs_d, bu_q, bu_d;
  logic                  tdo_q, tdo_d, oe_q, oe_d;
  jbs_pkg::jbs_sel_t     sel;
  logic                  drv_ext, flt;

  // Data register chosen by the current instruction
  always_comb
  begin
    case (ir_q)
      jbs_pkg::IR_IDCODE: sel = jbs_pkg::JBS_SEL_IDCODE;
      jbs_pkg::IR_SAMPLE,
      jbs_pkg::IR_EXTEST: sel = jbs_pkg::JBS_SEL_BSR;
      jbs_pkg::IR_HIGHZ:  sel = jbs_pkg::JBS_SEL_BYPASS;
      default:            sel = jbs_pkg::JBS_SEL_BYPASS;
    endcase
  end

  // Only extest takes the pins from the update cells
  assign drv_ext = (ir_q == jbs_pkg::IR_EXTEST);
  assign flt     = (ir_q == jbs_pkg::IR_HIGHZ);

  always_comb
  begin
    st_d  = st_q;
    ir_d  = ir_q;
    irs_d = irs_q;
    byp_d = byp_q;
    id_d  = id_q;
    bs_d  = bs_q;
    bu_d  = bu_q;
    tdo_d = tdo_q;
    oe_d  = oe_q;
    if (rise)
    begin
      // Standard sixteen-state walk on the synchronised mode select
      case (st_q)
        S_TLR:    st_d = s2_q.tms ? S_TLR : S_RTI;
        S_RTI:    st_d = s2_q.tms ? S_SEL_DR : S_RTI;
        S_SEL_DR: st_d = s2_q.tms ? S_SEL_IR : S_CAP_DR;
        S_CAP_DR: st_d = s2_q.tms ? S_EX1_DR : S_SH_DR;
        S_SH_DR:  st_d = s2_q.tms ? S_EX1_DR : S_SH_DR;
        S_EX1_DR: st_d = s2_q.tms ? S_UP_DR : S_PA_DR;
        S_PA_DR:  st_d = s2_q.tms ? S_EX2_DR : S_PA_DR;
        S_EX2_DR: st_d = s2_q.tms ? S_UP_DR : S_SH_DR;
        S_UP_DR:  st_d = s2_q.tms ? S_SEL_DR : S_RTI;
        S_SEL_IR: st_d = s2_q.tms ? S_TLR : S_CAP_IR;
        S_CAP_IR: st_d = s2_q.tms ? S_EX1_IR : S_SH_IR;
        S_SH_IR:  st_d = s2_q.tms ? S_EX1_IR : S_SH_IR;
        S_EX1_IR: st_d = s2_q.tms ? S_UP_IR : S_PA_IR;
        S_PA_IR:  st_d = s2_q.tms ? S_EX2_IR : S_PA_IR;
        S_EX2_IR: st_d = s2_q.tms ? S_UP_IR : S_SH_IR;
        S_UP_IR:  st_d = s2_q.tms ? S_SEL_DR : S_RTI;
        default:  st_d = S_TLR;
      endcase
      // Entering the reset state drops the instruction at once, not a clock later
      if (st_d == S_TLR)
        ir_d = jbs_pkg::IR_RESET;
      // Capture and shift on the rising edge, while the state still names them
      case (st_q)
        S_CAP_IR: irs_d = jbs_pkg::IR_CAPTURE;
        S_SH_IR:  irs_d = {s2_q.tdi, irs_q[jbs_pkg::IR_W-1:1]};
        S_CAP_DR:
        begin
          byp_d = 1'b0;
          id_d  = IDCODE;
          bs_d  = pin2_q;
        end
        S_SH_DR:
        begin
          byp_d = s2_q.tdi;
          id_d  = {s2_q.tdi, id_q[jbs_pkg::ID_W-1:1]};
          bs_d  = {s2_q.tdi, bs_q[NCELL-1:1]};
        end
        default: ;
      endcase
    end
    // Falling-edge retime keeps the bit stable across the tester's sample
    if (fall)
    begin
      oe_d = (st_q == S_SH_DR) || (st_q == S_SH_IR);
      if (st_q == S_SH_IR)
        tdo_d = irs_q[0];
      else
        case (sel)
          jbs_pkg::JBS_SEL_IDCODE: tdo_d = id_q[0];
          jbs_pkg::JBS_SEL_BSR:    tdo_d = bs_q[0];
          default:                 tdo_d = byp_q;
        endcase
      // Updates land on the falling edge, half a test clock after the update state is entered
      case (st_q)
        S_UP_IR: ir_d = irs_q;
        S_UP_DR:
          if (sel == jbs_pkg::JBS_SEL_BSR)
            bu_d = bs_q;
        default: ;
      endcase
    end
    // Test reset wins over a test clock edge in the same cycle for state, instruction, tdo and tdo_oe only
    if (trst_act)
    begin
      st_d  = S_TLR;
      ir_d  = jbs_pkg::IR_RESET;
      tdo_d = 1'b0;
      oe_d  = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q  <= S_TLR;
      ir_q  <= jbs_pkg::IR_RESET;
      irs_q <= '0;
      byp_q <= 1'b0;
      id_q  <= '0;
      bs_q  <= '0;
      bu_q  <= '0;
      tdo_q <= 1'b0;
      oe_q  <= 1'b0;
    end
    else
    begin
      st_q  <= st_d;
      ir_q  <= ir_d;
      irs_q <= irs_d;
      byp_q <= byp_d;
      id_q  <= id_d;
      bs_q  <= bs_d;
      bu_q  <= bu_d;
      tdo_q <= tdo_d;
      oe_q  <= oe_d;
    end
  end

  // Tdo keeps retiming the selected bit on each falling edge when released; the board's pull sets the idle level
  assign tdo     = tdo_q;
  assign tdo_oe  = oe_q;
  assign core_in = pad_in;
  // Extest drives pins from update latches; highz floats every scanned output
  assign pad_out = drv_ext ? bu_q : core_out;
  assign pad_oe  = flt ? '0 : (drv_ext ? {NCELL{1'b1}} : core_oe);

endmodule : jbs_tap

// >>> tb/jbs_tap_properties.sv
// Purpose: Port checks for jbs_tap
// Assumes: One clock domain, async resetn
// Notes:   Bound below; test reset may land mid-shift
`timescale 1ns/10ps
module jbs_tap_chk #(parameter int NCELL = 16) (
  input wire logic             clock,
  input wire logic             resetn,
  input wire logic             tck,
  input wire logic             tms,
  input wire logic             tdi,
  input wire logic             trst_n,
  input wire logic             tdo,
  input wire logic             tdo_oe,
  input wire logic [NCELL-1:0] core_out,
  input wire logic [NCELL-1:0] core_oe,
  input wire logic [NCELL-1:0] core_in,
  input wire logic [NCELL-1:0] pad_in,
  input wire logic [NCELL-1:0] pad_out,
  input wire logic [NCELL-1:0] pad_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_trst_held; !trst_n [*6]; endsequence
  sequence s_tdo_quiet; $stable(tdo) [*8]; endsequence
  a_tdo_fall_edge: assert property ($changed(tdo) |-> !tck) else $error("tdo moved, tck high");
  a_oe_fall_edge: assert property ($changed(tdo_oe) |-> !tck) else $error("tdo_oe moved");
  a_tdo_bit_hold: assert property ($changed(tdo) |=> s_tdo_quiet) else $error("tdo short");
  a_trst_idle: assert property (s_trst_held |-> !tdo_oe) else $error("tdo_oe in test reset");
  a_por_idle: assert property ($rose(resetn) |-> !tdo_oe && !tdo) else $error("out after por");
  a_pins_pass: assert property (core_in == pad_in) else $error("core_in not pad_in");
  a_oe_choice: assert property (pad_oe == core_oe || pad_oe == '0 || pad_oe == '1)
    else $error("pad_oe odd");
  a_highz_out: assert property (pad_oe == '0 && core_oe != '0 |-> pad_out == core_out)
    else $error("highz pad_out");
endmodule : jbs_tap_chk
bind jbs_tap jbs_tap_chk #(.NCELL(NCELL)) u_chk (.clock(clock), .resetn(resetn), .tck(tck),
  .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out),
  .core_oe(core_oe), .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));

// >>> tb/jbs_tester.sv
// Purpose: Boundary-scan tester model
// Assumes: Test clock 160 ns, still low between steps
// Notes:   Samples tdo just before each rising test clock
`timescale 1ns/10ps
module jbs_tester (
  input  wire logic clock,
  input  wire logic tdo,
  input  wire logic tdo_oe,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  output logic      trst_n
);
  // Clock idles low, matching the synchroniser reset, so no false edge
  initial {tck, tms, tdi, trst_n} = 4'h1;
  task automatic step(input logic m, d, output logic o);
    tms = m;
    tdi = d;
    repeat (8) @(negedge clock);
    // Released pin reads inverted, so a missing enable shows up
    o = tdo_oe ? tdo : ~tdo;
    tck = 1;
    repeat (8) @(negedge clock);
    tck = 0;
  endtask : step
  task automatic walk(input logic [7:0] ms, input int n);
    logic o;
    for (int i = 0; i < n; i++) step(ms[i], 1'b0, o);
  endtask : walk
  task automatic scan(input int n, input logic [63:0] di, output logic [63:0] dq);
    logic o;
    dq = '0;
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, di[i], o);
      dq[i] = o;
    end
    walk(8'h01, 2);
  endtask : scan
  task automatic dr(input int n, input logic [63:0] di, output logic [63:0] dq);
    walk(8'h01, 3);
    scan(n, di, dq);
  endtask : dr
  task automatic ir(input logic [5:0] op, output logic [63:0] dq);
    walk(8'h03, 4);
    scan(6, {58'h0, op}, dq);
  endtask : ir
  task automatic trst;
    trst_n = 0;
    repeat (40) @(negedge clock);
    trst_n = 1;
    walk(8'h00, 1);
  endtask : trst
endmodule : jbs_tester

// >>> tb/jbs_tap_tb.sv
// Purpose: Self-checking bench for jbs_tap
// Assumes: Eight scan cells
// Notes:   Tester model drives the test pins
`timescale 1ns/10ps
module jbs_tap_tb;
  logic clock = 0, resetn = 0, tck, tms, tdi, trst_n, tdo, tdo_oe;
  logic [7:0] core_out = 8'h5A, core_oe = 8'h0F, pad_in = 8'hA5, core_in, pad_out, pad_oe;
  logic [63:0] q;
  int fail_count = 0, total_checks = 0;
  always #5 clock = ~clock;
  jbs_tap #(.NCELL(8)) dut (.clock(clock), .resetn(resetn), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .core_out(core_out), .core_oe(core_oe),
    .core_in(core_in), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe));
  jbs_tester tst (.clock(clock), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
    .tdi(tdi), .trst_n(trst_n));
  task automatic chk(input string n, input logic [63:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d fails %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  task t_idcode;
    tst.trst();
    tst.dr(32, '0, q);
    chk("id_reset", {32'h0, jbs_pkg::IDCODE_DEF}, q);
    tst.ir(jbs_pkg::IR_IDCODE, q);
    tst.dr(32, '0, q);
    chk("id_load", {32'h0, jbs_pkg::IDCODE_DEF}, q);
    $display("idcode done");
  endtask : t_idcode
  // Top bypass bit is lost: one-cell path delays by one test clock
  task t_bypass(input logic [5:0] op);
    tst.ir(op, q);
    chk("ir_capture", {58'h0, jbs_pkg::IR_CAPTURE}, q);
    tst.dr(8, 64'h00B7, q);
    chk("bypass", 64'h006E, q);
    $display("bypass done %h", op);
  endtask : t_bypass
  task t_scan;
    tst.ir(jbs_pkg::IR_SAMPLE, q);
    tst.dr(8, 64'h003C, q);
    chk("sample", 64'h00A5, q);
    chk("pass_out", 64'h005A, pad_out);
    tst.ir(jbs_pkg::IR_EXTEST, q);
    chk("ext_oe", 64'h00FF, pad_oe);
    chk("ext_out", 64'h003C, pad_out);
    tst.ir(jbs_pkg::IR_HIGHZ, q);
    chk("highz_oe", 64'h0000, pad_oe);
    $display("scan done");
  endtask : t_scan
  // Test reset mid-shift: driver lets go, state and instruction return to reset
  task t_trst_mid;
    tst.ir(jbs_pkg::IR_BYPASS, q);
    tst.walk(8'h01, 3);
    repeat (12) @(negedge clock);
    chk("shift_oe", 64'h0001, tdo_oe);
    tst.trst();
    chk("trst_oe", 64'h0000, tdo_oe);
    tst.dr(32, '0, q);
    chk("id_trst", {32'h0, jbs_pkg::IDCODE_DEF}, q);
    $display("trst done");
  endtask : t_trst_mid
  initial
  begin
    repeat (16) @(negedge clock);
    resetn = 1;
    repeat (4) @(negedge clock);
    t_idcode;
    t_bypass(jbs_pkg::IR_BYPASS);
    t_scan;
    t_bypass(jbs_pkg::IR_HIGHZ);
    t_trst_mid;
    finish_test;
  end
  initial
  begin
    #500000;
    fail_count++;
    finish_test;
  end
endmodule : jbs_tap_tb
